//--- iosbc_pkg.sv
// Package for the sense and buffer channel control block.
// Assumes a single 100 MHz core clock domain.
package iosbc_pkg;
  localparam int CLK_PERIOD_NS = 10;
  localparam int EF_HOLD_US = 8;
  localparam int EF_HOLD_CYC = (EF_HOLD_US * 1000) / CLK_PERIOD_NS;
  localparam int NUM_CHAN = 6;
  localparam int ADDR_W = 15;
  localparam int WORD_W = 48;
  localparam int IA_HI = 38;
  localparam int IA_LO = 24;
  localparam int TA_HI = 14;
  localparam int TA_LO = 0;
  localparam logic [2:0] J_SELECT = 3'h0;
  localparam logic [2:0] J_SENSE = 3'h7;
  localparam int FIFO_DEPTH = 8;

  typedef enum logic [1:0] {
    IOSBC_OP_XFER,
    IOSBC_OP_CLOCK,
    IOSBC_OP_INTR
  } iosbc_op_t;

  typedef struct packed {
    logic [2:0] chan;
    logic [ADDR_W-1:0] code;
    logic upper;
  } iosbc_ef_t;

  typedef struct packed {
    logic write;
    logic [ADDR_W-1:0] addr;
    logic [WORD_W-1:0] wdata;
  } iosbc_mem_req_t;
endpackage

//--- iosbc_fifo.sv
// Word FIFO with valid/ready on both sides, flip-flop storage.
// Assumes one clock and an active-low asynchronous reset.
`timescale 1ns/100ps
`default_nettype none
module iosbc_fifo #(
  parameter int WIDTH = 48,
  parameter int DEPTH = 8
) (
  input wire logic i_core_clk,
  input wire logic i_rst_n,
  input wire logic i_in_valid,
  output logic o_in_ready,
  input wire logic [WIDTH-1:0] i_in_data,
  output logic o_out_valid,
  input wire logic i_out_ready,
  output logic [WIDTH-1:0] o_out_data
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem_reg [DEPTH];
  logic [AW-1:0] wr_reg;
  logic [AW-1:0] rd_reg;
  logic [AW:0] cnt_reg;
  logic push;
  logic pop;

  assign o_in_ready = (cnt_reg != (AW+1)'(DEPTH));
  assign o_out_valid = (cnt_reg != '0);
  assign o_out_data = mem_reg[rd_reg];
  assign push = i_in_valid && o_in_ready;
  assign pop = o_out_valid && i_out_ready;

  always_ff @(posedge i_core_clk) begin
    if (push) begin
      mem_reg[wr_reg] <= i_in_data;
    end
  end

  always_ff @(posedge i_core_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      wr_reg <= '0;
      rd_reg <= '0;
      cnt_reg <= '0;
    end else begin
      if (push) begin
        wr_reg <= (wr_reg == AW'(DEPTH - 1)) ? '0 : wr_reg + 1'b1;
      end
      if (pop) begin
        rd_reg <= (rd_reg == AW'(DEPTH - 1)) ? '0 : rd_reg + 1'b1;
      end
      cnt_reg <= cnt_reg + (AW+1)'(push) - (AW+1)'(pop);
    end
  end
endmodule
`default_nettype wire

//--- iosbc_top.sv
// Sense, external function and buffer channel control with aux sequence.
// Assumes a one-cycle storage port and handshake pins synchronous here,
// except the output resume, which passes a sync flag first.
// Overview of operation
// - Hold select and sense codes on lines 8 us
// - Sense code to channel 1-7 or internal
// - Low code bit inverts returned sense response
// - Resynced result picks full or half exit
// - Upper sense: full skips, half executes lower
// - Lower sense: full advances, half repeats
// - Designator 1-6 activates that buffer channel
// - Initial address into bits 38-24 of word j
// - Same storage cycle keeps terminal address
// - Active flag set when addresses differ
// - Return to fetch via complemented exit flag
// - Aux does transfer, clock advance, interrupt
// - Aux request suspends program, then resumes
// - Aux starts at exit, transfer end, stop
// - One word per operation, equipment paced
// - Read control word, move word, answer
// - Increment, write back, compare, maybe inactive
// - Aux exits after buffer steps
// - Resume sampled even, acted on odd
`timescale 1ns/100ps
`default_nettype none
module iosbc_top #(
  parameter int NCH = iosbc_pkg::NUM_CHAN,
  parameter int HOLD_CYC = iosbc_pkg::EF_HOLD_CYC,
  parameter int FDEPTH = iosbc_pkg::FIFO_DEPTH
) (
  input wire logic i_core_clk,
  input wire logic i_rst_n,
  input wire logic i_ef_start,
  input wire iosbc_pkg::iosbc_ef_t i_ef,
  output logic o_ef_busy,
  output logic o_ef_done,
  output logic o_full_exit,
  output logic o_skip_lower,
  output logic o_repeat,
  output logic o_ef_line_valid,
  output logic [2:0] o_ef_line_chan,
  output logic [iosbc_pkg::ADDR_W-1:0] o_ef_line_code,
  input wire logic i_sense_resp,
  input wire logic [NCH-1:0] i_internal_cond,
  input wire logic i_seq_exit,
  input wire logic i_xfer_done,
  input wire logic i_stopped,
  input wire logic i_clock_req,
  input wire logic i_intr_req,
  output logic o_prog_hold,
  output logic o_aux_active,
  output iosbc_pkg::iosbc_op_t o_aux_op,
  output logic o_exit_choice,
  output logic [NCH-1:0] o_channel_active,
  output logic o_mem_en,
  output iosbc_pkg::iosbc_mem_req_t o_mem_req,
  input wire logic [iosbc_pkg::WORD_W-1:0] i_mem_rdata,
  input wire logic [NCH-1:0] i_chan_is_input,
  input wire logic [NCH-1:0] i_in_ready,
  input wire logic [NCH-1:0] i_out_resume,
  input wire logic [iosbc_pkg::WORD_W-1:0] i_in_data,
  output logic [NCH-1:0] o_in_resume,
  output logic [NCH-1:0] o_out_ready,
  output logic o_out_valid,
  input wire logic i_out_take,
  output logic [iosbc_pkg::WORD_W-1:0] o_out_data
);
  localparam int AW = iosbc_pkg::ADDR_W;
  localparam int WW = iosbc_pkg::WORD_W;
  localparam int CW = $clog2(HOLD_CYC + 1);

  typedef enum logic [3:0] {
    ST_IDLE, ST_EF_HOLD, ST_EF_RESYNC, ST_ACT_RMW, ST_ACT_CMP,
    ST_AUX_READ, ST_AUX_DATA, ST_AUX_WB, ST_AUX_EXIT
  } iosbc_state_t;

  iosbc_state_t st_reg;
  iosbc_pkg::iosbc_ef_t ef_reg;
  logic [CW-1:0] hold_cnt_reg;
  logic sense_resync_reg;
  logic exit_choice_flag_reg;
  logic [NCH-1:0] channel_active_flag_reg;
  logic [NCH-1:0] resume_sync_flag_reg;
  logic [NCH-1:0] wait_resume_reg;
  logic [NCH-1:0] action_req_reg;
  logic [NCH-1:0] in_resume_reg;
  logic sync_even_reg;
  logic [2:0] scan_reg;
  logic [WW-1:0] ctl_reg;
  logic [WW-1:0] out_word_reg;
  logic out_push_reg;
  logic fifo_in_ready;
  logic aux_req;
  logic aux_start;
  logic scan_hit;
  logic cur_in;
  logic [AW-1:0] ia_inc;

  function automatic logic [AW-1:0] ia_of(input logic [WW-1:0] w);
    ia_of = w[iosbc_pkg::IA_HI:iosbc_pkg::IA_LO];
  endfunction

  function automatic logic [AW-1:0] ta_of(input logic [WW-1:0] w);
    ta_of = w[iosbc_pkg::TA_HI:iosbc_pkg::TA_LO];
  endfunction

  // Requests from the ready/resume lines and the other aux sources
  assign aux_req = (|action_req_reg) || i_clock_req || i_intr_req;
  // Scanner parked on a position that asks for service
  assign scan_hit = (scan_reg == 3'h0) ? (i_clock_req || i_intr_req) :
                    action_req_reg[scan_reg - 3'h1];
  assign aux_start = (st_reg == ST_IDLE) && scan_hit &&
                     (i_seq_exit || i_xfer_done || i_stopped);
  assign cur_in = i_chan_is_input[scan_reg - 3'h1];
  assign ia_inc = ia_of(ctl_reg) + AW'(1);

  // hold program while aux or function runs
  assign o_prog_hold = (st_reg != ST_IDLE);
  assign o_aux_active = (st_reg == ST_AUX_READ) || (st_reg == ST_AUX_DATA) ||
                        (st_reg == ST_AUX_WB) || (st_reg == ST_AUX_EXIT);
  assign o_ef_busy = (st_reg == ST_EF_HOLD) || (st_reg == ST_EF_RESYNC) ||
                     (st_reg == ST_ACT_RMW) || (st_reg == ST_ACT_CMP);
  assign o_exit_choice = exit_choice_flag_reg;
  assign o_channel_active = channel_active_flag_reg;
  assign o_in_resume = in_resume_reg;
  assign o_out_ready = wait_resume_reg;
  // code held on lines during the hold count
  assign o_ef_line_valid = (st_reg == ST_EF_HOLD);
  assign o_ef_line_chan = ef_reg.chan;
  // low code bit of a sense code is withheld from the lines
  assign o_ef_line_code = (ef_reg.chan == iosbc_pkg::J_SENSE) ?
                          {ef_reg.code[AW-1:1], 1'b0} : ef_reg.code;
  assign o_aux_op = (scan_reg != 3'h0) ? iosbc_pkg::IOSBC_OP_XFER :
                    (i_clock_req ? iosbc_pkg::IOSBC_OP_CLOCK :
                     iosbc_pkg::IOSBC_OP_INTR);

  // Main sequencer
  always_ff @(posedge i_core_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      st_reg <= ST_IDLE;
      ef_reg <= '0;
      hold_cnt_reg <= '0;
      sense_resync_reg <= 1'b0;
      exit_choice_flag_reg <= 1'b0;
      ctl_reg <= '0;
      o_ef_done <= 1'b0;
      o_full_exit <= 1'b0;
      o_skip_lower <= 1'b0;
      o_repeat <= 1'b0;
      o_mem_en <= 1'b0;
      o_mem_req <= '0;
      out_push_reg <= 1'b0;
      out_word_reg <= '0;
    end else begin
      o_ef_done <= 1'b0;
      o_mem_en <= 1'b0;
      out_push_reg <= 1'b0;
      unique case (st_reg)
        ST_IDLE: begin
          if (aux_start && scan_reg != 3'h0) begin
            st_reg <= ST_AUX_READ;
            o_mem_en <= 1'b1;
            o_mem_req <= '{write: 1'b0, addr: AW'(scan_reg), wdata: '0};
          end else if (aux_start) begin
            st_reg <= ST_AUX_EXIT;
          end else if (i_ef_start) begin
            ef_reg <= i_ef;
            if (i_ef.chan != iosbc_pkg::J_SELECT &&
                i_ef.chan != iosbc_pkg::J_SENSE) begin
              st_reg <= ST_ACT_RMW;
              exit_choice_flag_reg <= ~exit_choice_flag_reg;
              o_mem_en <= 1'b1;
              o_mem_req <= '{write: 1'b0, addr: AW'(i_ef.chan), wdata: '0};
            end else begin
              st_reg <= ST_EF_HOLD;
              hold_cnt_reg <= CW'(HOLD_CYC - 1);
            end
          end
        end
        ST_EF_HOLD: begin
          if (hold_cnt_reg == '0) begin
            st_reg <= ST_EF_RESYNC;
            // internal condition when channel field is zero
            // response combined with low code bit
            sense_resync_reg <= (ef_reg.chan == iosbc_pkg::J_SENSE) ?
              (((ef_reg.code[AW-1:4] == '0 && ef_reg.code[3:1] != '0) ?
                i_internal_cond[ef_reg.code[3:1] - 3'h1] : i_sense_resp)
               ^ ef_reg.code[0]) : 1'b1;
          end else begin
            hold_cnt_reg <= hold_cnt_reg - 1'b1;
          end
        end
        ST_EF_RESYNC: begin
          // full exit on one, half exit on zero
          o_ef_done <= 1'b1;
          o_full_exit <= sense_resync_reg;
          o_skip_lower <= ef_reg.upper && sense_resync_reg;
          o_repeat <= !ef_reg.upper && !sense_resync_reg;
          st_reg <= ST_IDLE;
        end
        ST_ACT_RMW: begin
          ctl_reg <= i_mem_rdata;
          ctl_reg[iosbc_pkg::IA_HI:iosbc_pkg::IA_LO] <= ef_reg.code;
          o_mem_en <= 1'b1;
          o_mem_req <= '{write: 1'b1, addr: AW'(ef_reg.chan),
                         wdata: {i_mem_rdata[WW-1:iosbc_pkg::IA_HI+1],
                                 ef_reg.code,
                                 i_mem_rdata[iosbc_pkg::IA_LO-1:0]}};
          st_reg <= ST_ACT_CMP;
        end
        ST_ACT_CMP: begin
          o_ef_done <= 1'b1;
          o_full_exit <= exit_choice_flag_reg;
          o_skip_lower <= 1'b0;
          o_repeat <= 1'b0;
          st_reg <= ST_IDLE;
        end
        ST_AUX_READ: begin
          ctl_reg <= i_mem_rdata;
          o_mem_en <= 1'b1;
          // word stored or fetched at initial address
          o_mem_req <= '{write: cur_in, addr: ia_of(i_mem_rdata),
                         wdata: i_in_data};
          st_reg <= ST_AUX_DATA;
        end
        ST_AUX_DATA: begin
          if (!cur_in) begin
            out_word_reg <= i_mem_rdata;
            out_push_reg <= 1'b1;
          end
          o_mem_en <= 1'b1;
          o_mem_req <= '{write: 1'b1, addr: AW'(scan_reg),
                         wdata: {ctl_reg[WW-1:iosbc_pkg::IA_HI+1], ia_inc,
                                 ctl_reg[iosbc_pkg::IA_LO-1:0]}};
          st_reg <= ST_AUX_WB;
        end
        ST_AUX_WB: begin
          st_reg <= ST_AUX_EXIT;
        end
        ST_AUX_EXIT: begin
          st_reg <= ST_IDLE;
        end
        default: st_reg <= ST_IDLE;
      endcase
    end
  end

  // Active flags: on activation, on each transfer
  always_ff @(posedge i_core_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      channel_active_flag_reg <= '0;
    end else if (st_reg == ST_ACT_CMP) begin
      channel_active_flag_reg[ef_reg.chan - 3'h1] <=
        (ia_of(ctl_reg) != ta_of(ctl_reg));
    end else if (st_reg == ST_AUX_WB && scan_reg != 3'h0) begin
      channel_active_flag_reg[scan_reg - 3'h1] <= (ia_inc != ta_of(ctl_reg));
    end
  end

  // scanner advances while idle unless stopped on a requester
  always_ff @(posedge i_core_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      scan_reg <= 3'h0;
      sync_even_reg <= 1'b0;
    end else begin
      sync_even_reg <= ~sync_even_reg;
      if (st_reg == ST_IDLE && !aux_req) begin
        scan_reg <= (scan_reg == 3'(NCH)) ? 3'h0 : scan_reg + 3'h1;
      end else if (st_reg == ST_IDLE && scan_reg != 3'h0 &&
                   !action_req_reg[scan_reg - 3'h1]) begin
        scan_reg <= (scan_reg == 3'(NCH)) ? 3'h0 : scan_reg + 3'h1;
      end else if (st_reg == ST_IDLE && scan_reg == 3'h0 &&
                   !i_clock_req && !i_intr_req) begin
        scan_reg <= 3'h1;
      end
    end
  end

  // Per channel handshake logic
  genvar g;
  generate
    for (g = 0; g < NCH; g++) begin : g_chan
      logic done_here;
      assign done_here = (st_reg == ST_AUX_WB) && (scan_reg == 3'(g + 1));
      always_ff @(posedge i_core_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
          resume_sync_flag_reg[g] <= 1'b0;
          wait_resume_reg[g] <= 1'b0;
          action_req_reg[g] <= 1'b0;
          in_resume_reg[g] <= 1'b0;
        end else begin
          if (sync_even_reg) begin
            resume_sync_flag_reg[g] <= i_out_resume[g];
          end
          // one word per request, paced by equipment
          if (done_here) begin
            action_req_reg[g] <= 1'b0;
            wait_resume_reg[g] <= !i_chan_is_input[g] &&
                                  channel_active_flag_reg[g];
            in_resume_reg[g] <= i_chan_is_input[g];
          end else begin
            in_resume_reg[g] <= in_resume_reg[g] && i_in_ready[g];
            if (!sync_even_reg && resume_sync_flag_reg[g]) begin
              // odd pulse acts on resume flag
              wait_resume_reg[g] <= 1'b0;
              action_req_reg[g] <= channel_active_flag_reg[g] &&
                                   wait_resume_reg[g];
            end else if (i_chan_is_input[g] && i_in_ready[g] &&
                         !in_resume_reg[g] && channel_active_flag_reg[g]) begin
              action_req_reg[g] <= 1'b1;
            end else if (!i_chan_is_input[g] && channel_active_flag_reg[g] &&
                         !wait_resume_reg[g] && !action_req_reg[g] &&
                         !resume_sync_flag_reg[g] && fifo_in_ready) begin
              action_req_reg[g] <= 1'b1;
            end else if (!channel_active_flag_reg[g]) begin
              // Drop a stale request once the channel is inactive
              action_req_reg[g] <= 1'b0;
            end
          end
        end
      end
    end
  endgenerate

  iosbc_fifo #(.WIDTH(WW), .DEPTH(FDEPTH)) u_out_fifo (
    .i_core_clk(i_core_clk),
    .i_rst_n(i_rst_n),
    .i_in_valid(out_push_reg),
    .o_in_ready(fifo_in_ready),
    .i_in_data(out_word_reg),
    .o_out_valid(o_out_valid),
    .i_out_ready(i_out_take),
    .o_out_data(o_out_data)
  );

  // code held for at least 8 cycles
  a_ef_hold_len: assert property (
    @(posedge i_core_clk) disable iff (!i_rst_n)
    $rose(o_ef_line_valid) |-> o_ef_line_valid [*8])
    else $error("function code dropped early");
  // low sense bit kept off the lines
  a_sense_low_bit: assert property (
    @(posedge i_core_clk) disable iff (!i_rst_n)
    o_ef_line_valid && o_ef_line_chan == iosbc_pkg::J_SENSE |->
      !o_ef_line_code[0])
    else $error("sense low bit on lines");
  // repeat only on lower half exit
  a_sense_repeat: assert property (
    @(posedge i_core_clk) disable iff (!i_rst_n)
    o_ef_done && o_repeat |-> !o_full_exit)
    else $error("repeat with full exit");
  a_aux_hold: assert property (
    @(posedge i_core_clk) disable iff (!i_rst_n)
    o_aux_active |-> o_prog_hold)
    else $error("aux without program hold");
  // aux begins only at an opportunity
  a_aux_start: assert property (
    @(posedge i_core_clk) disable iff (!i_rst_n)
    $rose(o_aux_active) |->
      $past(i_seq_exit) || $past(i_xfer_done) || $past(i_stopped))
    else $error("aux began without opportunity");
  // control read, word access, write back
  sequence s_buf_steps;
    o_mem_en && !o_mem_req.write ##1 o_mem_en ##1
      o_mem_en && o_mem_req.write;
  endsequence
  a_buf_steps: assert property (
    @(posedge i_core_clk) disable iff (!i_rst_n)
    $rose(o_aux_active) && o_aux_op == iosbc_pkg::IOSBC_OP_XFER |->
      s_buf_steps)
    else $error("buffer steps out of order");
  a_aux_exit: assert property (
    @(posedge i_core_clk) disable iff (!i_rst_n)
    $rose(o_aux_active) |-> ##[1:4] !o_aux_active)
    else $error("aux did not exit");
endmodule
`default_nettype wire

//--- iosbc_equip_model.sv
// Behavioural equipment on the six channel cables, input and output.
// Assumes one word in flight on the shared data lines at a time.
`timescale 1ns/100ps
`default_nettype none
module iosbc_equip_model (
  input wire logic i_core_clk,
  input wire logic i_rst_n,
  input wire logic [5:0] i_in_en,
  input wire logic [3:0] i_delay,
  input wire logic [5:0] i_in_resume,
  input wire logic [5:0] i_out_ready,
  input wire logic i_out_valid,
  input wire logic [47:0] i_out_data,
  output logic [5:0] o_in_ready,
  output logic [5:0] o_out_resume,
  output logic o_out_take,
  output logic [47:0] o_in_data,
  output logic [3:0] o_rx_cnt,
  output logic [7:0][47:0] o_rx_word
);
  localparam logic [47:0] IN_BASE = 48'hC0DE00000000;
  logic [3:0] in_cnt;
  logic [3:0] in_wait;
  logic [3:0] out_wait;
  logic in_busy;
  logic out_busy;

  // ready only while a fresh word is held
  always_ff @(posedge i_core_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_in_ready <= 6'h00;
      in_busy <= 1'b0;
      in_cnt <= 4'h0;
      in_wait <= 4'h0;
    end else if (|(o_in_ready & i_in_resume)) begin
      o_in_ready <= 6'h00;
      in_busy <= 1'b1;
      in_cnt <= in_cnt + 4'h1;
    end else if (in_busy) begin
      if (~|i_in_resume) begin
        in_busy <= 1'b0;
        in_wait <= 4'h0;
      end
    end else if (in_wait < i_delay) begin
      in_wait <= in_wait + 4'h1;
    end else begin
      o_in_ready <= i_in_en;
    end
  end

  // Released lines show the inverse, not the last word
  assign o_in_data = (|o_in_ready) ? IN_BASE + {44'h0, in_cnt} :
                     ~(IN_BASE + {44'h0, in_cnt});

  // sample the word, then resume after a delay
  always_ff @(posedge i_core_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_out_take <= 1'b0;
      o_out_resume <= 6'h00;
      out_busy <= 1'b0;
      out_wait <= 4'h0;
      o_rx_cnt <= 4'h0;
    end else if (o_out_take) begin
      o_out_take <= 1'b0;
      o_rx_word[o_rx_cnt[2:0]] <= i_out_data;
      o_rx_cnt <= o_rx_cnt + 4'h1;
      out_busy <= 1'b1;
      out_wait <= 4'h0;
    end else if (!out_busy) begin
      o_out_take <= i_out_valid && (|i_out_ready);
    end else if (|o_out_resume) begin
      if (~|(o_out_resume & i_out_ready)) begin
        o_out_resume <= 6'h00;
        out_busy <= 1'b0;
      end
    end else if (out_wait < i_delay) begin
      out_wait <= out_wait + 4'h1;
    end else begin
      o_out_resume <= i_out_ready;
    end
  end
endmodule
`default_nettype wire

//--- testbench.sv
// Self-checking bench: function codes, sense exits, activation, buffering.
// Assumes a one-cycle storage model here and the equipment model beside.
`timescale 1ns/100ps
`default_nettype none
`define CHK(got, exp) begin tests_run++; if ((got) !== (exp)) begin \
  failures++; $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp); \
  end end
module testbench;
  localparam int HOLD = 8;
  localparam logic [47:0] IN_BASE = 48'hC0DE00000000;
  logic i_core_clk, i_rst_n, i_ef_start, i_sense_resp, i_seq_exit;
  logic i_xfer_done, i_stopped, i_clock_req, i_intr_req, i_out_take;
  iosbc_pkg::iosbc_ef_t i_ef;
  logic o_ef_busy, o_ef_done, o_full_exit, o_skip_lower, o_repeat;
  logic o_ef_line_valid, o_prog_hold, o_aux_active, o_exit_choice;
  logic o_mem_en, o_out_valid;
  logic [2:0] o_ef_line_chan;
  logic [14:0] o_ef_line_code;
  logic [5:0] i_internal_cond, o_channel_active, i_chan_is_input;
  logic [5:0] i_in_ready, i_out_resume, o_in_resume, o_out_ready, in_en;
  iosbc_pkg::iosbc_op_t o_aux_op;
  iosbc_pkg::iosbc_mem_req_t o_mem_req;
  logic [47:0] i_mem_rdata, i_in_data, o_out_data;
  logic [3:0] delay, rx_cnt;
  logic [7:0][47:0] rx_word;
  logic [47:0] mem [0:1023];
  int failures, tests_run;

  iosbc_top #(.HOLD_CYC(HOLD)) iosbc_top_i (.i_core_clk, .i_rst_n,
    .i_ef_start, .i_ef, .o_ef_busy, .o_ef_done, .o_full_exit,
    .o_skip_lower, .o_repeat, .o_ef_line_valid, .o_ef_line_chan,
    .o_ef_line_code, .i_sense_resp, .i_internal_cond, .i_seq_exit,
    .i_xfer_done, .i_stopped, .i_clock_req, .i_intr_req, .o_prog_hold,
    .o_aux_active, .o_aux_op, .o_exit_choice, .o_channel_active,
    .o_mem_en, .o_mem_req, .i_mem_rdata, .i_chan_is_input, .i_in_ready,
    .i_out_resume, .i_in_data, .o_in_resume, .o_out_ready, .o_out_valid,
    .i_out_take, .o_out_data);

  iosbc_equip_model iosbc_equip_model_i (.i_core_clk, .i_rst_n,
    .i_in_en(in_en), .i_delay(delay), .i_in_resume(o_in_resume),
    .i_out_ready(o_out_ready), .i_out_valid(o_out_valid),
    .i_out_data(o_out_data), .o_in_ready(i_in_ready),
    .o_out_resume(i_out_resume), .o_out_take(i_out_take),
    .o_in_data(i_in_data), .o_rx_cnt(rx_cnt), .o_rx_word(rx_word));

  // Storage answers in the request cycle, writes at its end
  assign i_mem_rdata = mem[o_mem_req.addr[9:0]];
  always @(posedge i_core_clk) begin
    if (o_mem_en) begin
      if (o_mem_req.write) begin
        mem[o_mem_req.addr[9:0]] <= o_mem_req.wdata;
      end
    end
  end

  initial begin
    i_core_clk = 1'b0;
    forever #5 i_core_clk = ~i_core_clk;
  end

  task automatic run_ef(input logic [2:0] ch, input logic [14:0] code,
                        input logic up, output int lv,
                        output logic [14:0] lc);
    int n;
    @(negedge i_core_clk);
    i_ef = '{chan: ch, code: code, upper: up};
    i_ef_start = 1'b1;
    @(negedge i_core_clk);
    i_ef_start = 1'b0;
    lv = 0;
    n = 0;
    lc = 15'h0000;
    while (o_ef_done !== 1'b1 && n < 2000) begin
      if (o_ef_line_valid === 1'b1) begin
        lv++;
        lc = o_ef_line_code;
      end
      n++;
      @(negedge i_core_clk);
    end
    `CHK(o_ef_done, 1'b1)
  endtask

  task automatic t_select;
    int lv;
    logic [14:0] lc;
    run_ef(iosbc_pkg::J_SELECT, 15'h5A5A, 1'b0, lv, lc);
    `CHK(lv >= HOLD && lv <= HOLD + 2, 1'b1)
    `CHK(lc, 15'h5A5A)
    $display("test select done");
  endtask

  task automatic t_sense;
    int lv;
    logic [14:0] lc;
    logic full;
    for (int k = 0; k < 8; k++) begin
      i_sense_resp = k[0];
      full = k[0] ^ k[1];
      run_ef(iosbc_pkg::J_SENSE, {14'h2468, k[1]}, k[2], lv, lc);
      `CHK(o_full_exit, full)
      `CHK(o_skip_lower, k[2] & full)
      `CHK(o_repeat, ~k[2] & ~full)
      `CHK(lc, {14'h2468, 1'b0})
      `CHK(lv >= HOLD, 1'b1)
    end
    // Internal conditions named by the low code digits
    i_sense_resp = 1'b1;
    run_ef(iosbc_pkg::J_SENSE, 15'h0004, 1'b0, lv, lc);
    `CHK(o_full_exit, 1'b0)
    i_sense_resp = 1'b0;
    run_ef(iosbc_pkg::J_SENSE, 15'h0002, 1'b0, lv, lc);
    `CHK(o_full_exit, 1'b1)
    $display("test sense done");
  endtask

  task automatic t_activate;
    int lv;
    logic [14:0] lc, init, term;
    logic prev;
    for (int ch = 1; ch < 7; ch++) begin
      init = 15'h0100 * ch[14:0];
      term = (ch == 4) ? init : init + ch[14:0];
      mem[ch] = {9'h1A5, 15'h7000, 9'h0C3, term};
      prev = o_exit_choice;
      run_ef(ch[2:0], init, 1'b0, lv, lc);
      @(negedge i_core_clk);
      `CHK(mem[ch], {9'h1A5, init, 9'h0C3, term})
      `CHK(o_channel_active[ch-1], init != term)
      `CHK(o_exit_choice, ~prev)
      run_ef(ch[2:0], term, 1'b0, lv, lc);
      @(negedge i_core_clk);
      `CHK(o_channel_active[ch-1], 1'b0)
    end
    $display("test activate done");
  endtask

  task automatic t_buf_in;
    int lv, n;
    logic [14:0] lc;
    logic seen, bad;
    // terminal one past the last word, loaded first
    mem[2] = {33'h0, 15'h0103};
    run_ef(3'h2, 15'h0100, 1'b0, lv, lc);
    delay = 4'h2;
    in_en = 6'h02;
    seen = 1'b0;
    bad = 1'b0;
    repeat (20) begin
      @(negedge i_core_clk);
      seen |= (o_aux_active === 1'b1);
    end
    `CHK(seen, 1'b0)
    i_seq_exit = 1'b1;
    n = 0;
    while (o_channel_active[1] !== 1'b0 && n < 1000) begin
      @(negedge i_core_clk);
      seen |= (o_aux_active === 1'b1);
      bad |= (o_aux_active === 1'b1) && (o_prog_hold !== 1'b1 ||
             o_aux_op !== iosbc_pkg::IOSBC_OP_XFER);
      n++;
    end
    i_seq_exit = 1'b0;
    in_en = 6'h00;
    repeat (10) @(negedge i_core_clk);
    `CHK(seen, 1'b1)
    `CHK(bad, 1'b0)
    `CHK(o_prog_hold, 1'b0)
    for (int k = 0; k < 3; k++) begin
      `CHK(mem[256 + k], IN_BASE + k)
    end
    `CHK(mem[259], 48'h0)
    `CHK(mem[2][38:24], 15'h0103)
    $display("test buffer input done");
  endtask

  task automatic t_buf_out;
    int lv, n, rcnt;
    logic [14:0] lc;
    logic early;
    mem[3] = {33'h0, 15'h0203};
    for (int k = 0; k < 3; k++) begin
      mem[512 + k] = 48'h5A0000000000 + k;
    end
    delay = 4'h6;
    run_ef(3'h3, 15'h0200, 1'b0, lv, lc);
    i_stopped = 1'b1;
    n = 0;
    rcnt = 0;
    early = 1'b0;
    while ((o_channel_active[2] !== 1'b0 || rx_cnt !== 4'h3) && n < 3000) begin
      @(negedge i_core_clk);
      rcnt = (i_out_resume[2] === 1'b1) ? rcnt + 1 : 0;
      if (rcnt == 1 && o_out_ready[2] !== 1'b1) begin
        early = 1'b1;
      end
      n++;
    end
    i_stopped = 1'b0;
    repeat (20) @(negedge i_core_clk);
    `CHK(early, 1'b0)
    `CHK(rx_cnt, 4'h3)
    for (int k = 0; k < 3; k++) begin
      `CHK(rx_word[k], 48'h5A0000000000 + k)
    end
    `CHK(mem[3][38:24], 15'h0203)
    `CHK(o_aux_active, 1'b0)
    $display("test buffer output done");
  endtask

  task automatic t_aux_other;
    int n;
    iosbc_pkg::iosbc_op_t op;
    i_stopped = 1'b1;
    for (int k = 0; k < 2; k++) begin
      i_clock_req = (k == 0);
      i_intr_req = (k == 1);
      op = (k == 0) ? iosbc_pkg::IOSBC_OP_CLOCK : iosbc_pkg::IOSBC_OP_INTR;
      n = 0;
      while (o_aux_active !== 1'b1 && n < 50) begin
        @(negedge i_core_clk);
        n++;
      end
      `CHK(o_aux_op, op)
      `CHK(o_prog_hold, 1'b1)
      i_clock_req = 1'b0;
      i_intr_req = 1'b0;
      repeat (2) @(negedge i_core_clk);
    end
    i_stopped = 1'b0;
    repeat (2) @(negedge i_core_clk);
    `CHK(o_aux_active, 1'b0)
    $display("test clock and interrupt done");
  endtask

  task end_of_test;
    $display("tests_run=%0d failures=%0d", tests_run, failures);
    if (failures == 0 && tests_run > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  initial begin
    repeat (40000) @(posedge i_core_clk);
    failures++;
    end_of_test();
  end

  initial begin
    failures = 0;
    tests_run = 0;
    i_rst_n = 1'b0;
    i_ef_start = 1'b0;
    i_ef = '0;
    i_sense_resp = 1'b0;
    i_seq_exit = 1'b0;
    i_xfer_done = 1'b0;
    i_stopped = 1'b0;
    i_clock_req = 1'b0;
    i_intr_req = 1'b0;
    i_internal_cond = 6'h15;
    i_chan_is_input = 6'h02;
    in_en = 6'h00;
    delay = 4'h0;
    for (int a = 0; a < 1024; a++) begin
      mem[a] = 48'h0;
    end
    repeat (20) @(negedge i_core_clk);
    i_rst_n = 1'b1;
    t_select();
    t_sense();
    t_activate();
    t_buf_in();
    t_buf_out();
    t_aux_other();
    end_of_test();
  end
endmodule
`default_nettype wire
